// File: hdl/ilt_code_extra.sv
// Total cycles of a code-memory read from alignment and flash read timing.
// Assumes the timing field is a small wait count; result is clamped to the range.
`timescale 1ns/10ps
module ilt_code_extra
(
  input  wire logic [1:0] fetch_align,
  input  wire logic [1:0] flash_read_timing_field,
  output logic      [2:0] total_cyc
);
  logic [3:0] sum;

  always_comb
  begin
    sum = 4'(ilt_pkg::CYC_CODE_MIN) + 4'(flash_read_timing_field) + 4'((fetch_align & ilt_pkg::ALIGN_MASK) != 2'h0);
    if (sum > 4'(ilt_pkg::CYC_CODE_MAX))
    begin
      total_cyc = ilt_pkg::CYC_CODE_MAX;
    end
    else
    begin
      total_cyc = sum[2:0];
    end
  end
endmodule

// File: hdl/ilt_decode.sv
// Maps an instruction class to its length and base cycle count.
// Assumes the class is already decoded; code reads get extra cycles elsewhere.
`timescale 1ns/10ps
module ilt_decode
(
  input  wire ilt_pkg::ilt_op_t op,
  output logic [1:0]            len,
  output logic [2:0]            cyc,
  output logic                  is_code_rd,
  output logic                  known
);
  always_comb
  begin
    len        = ilt_pkg::LEN_ONE;
    cyc        = ilt_pkg::CYC_ONE;
    is_code_rd = 1'b0;
    known      = 1'b1;
    unique case (op)
      ilt_pkg::ILT_OR_A_IND:    begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_OR_A_IMM:    begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_OR_DIR_A:    begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_OR_DIR_IMM:  begin len = ilt_pkg::LEN_THREE; cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_XOR_A_REG:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_ONE;   end
      ilt_pkg::ILT_XOR_A_DIR:   begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_XOR_A_IND:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_XOR_A_IMM:   begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_XOR_DIR_A:   begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_XOR_DIR_IMM: begin len = ilt_pkg::LEN_THREE; cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_RL_A,
      ilt_pkg::ILT_RLC_A:       begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_ONE;   end
      ilt_pkg::ILT_RR_A,
      ilt_pkg::ILT_RRC_A,
      ilt_pkg::ILT_CLR_A,
      ilt_pkg::ILT_CPL_A,
      ilt_pkg::ILT_SWAP_A:      begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_ONE;   end
      ilt_pkg::ILT_MOV_A_REG:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_ONE;   end
      ilt_pkg::ILT_MOV_A_DIR:   begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_A_IND:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_A_IMM:   begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_REG_A:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_ONE;   end
      ilt_pkg::ILT_MOV_REG_DIR,
      ilt_pkg::ILT_MOV_REG_IMM: begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_DIR_A,
      ilt_pkg::ILT_MOV_DIR_REG: begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_DIR_DIR: begin len = ilt_pkg::LEN_THREE; cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_MOV_DIR_IND: begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_DIR_IMM: begin len = ilt_pkg::LEN_THREE; cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_MOV_IND_A:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_IND_DIR,
      ilt_pkg::ILT_MOV_IND_IMM: begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      ilt_pkg::ILT_MOV_SIXTEEN_BIT_DATA_POINTER_IMM: begin len = ilt_pkg::LEN_THREE; cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_CODE_RD_DP,
      ilt_pkg::ILT_CODE_RD_PC:
      begin
        len        = ilt_pkg::LEN_ONE;
        cyc        = ilt_pkg::CYC_CODE_MIN;
        is_code_rd = 1'b1;
      end
      ilt_pkg::ILT_EXT_RD_IND,
      ilt_pkg::ILT_EXT_WR_IND:  begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_EXT_RD_DP:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_EXT_WR_DP:   begin len = ilt_pkg::LEN_ONE;   cyc = ilt_pkg::CYC_THREE; end
      ilt_pkg::ILT_PUSH_DIR:    begin len = ilt_pkg::LEN_TWO;   cyc = ilt_pkg::CYC_TWO;   end
      default:                  known = 1'b0;
    endcase
  end
endmodule

// File: hdl/ilt_pkg.sv
// Constants for the instruction length and timing slice of the core decoder.
// Assumes a single core clock; counts are in core clock periods.
package ilt_pkg;

  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam logic [2:0]  CYC_ONE         = 3'h1;
  localparam logic [2:0]  CYC_TWO         = 3'h2;
  localparam logic [2:0]  CYC_THREE       = 3'h3;
  localparam logic [2:0]  CYC_CODE_MIN    = 3'h4;
  localparam logic [2:0]  CYC_CODE_MAX    = 3'h7;
  localparam logic [1:0]  LEN_ONE         = 2'h1;
  localparam logic [1:0]  LEN_TWO         = 2'h2;
  localparam logic [1:0]  LEN_THREE       = 2'h3;
  localparam int unsigned TIMING_W        = 2;
  localparam logic [1:0]  ALIGN_MASK      = 2'h3;

  // Instruction classes handled by this slice.
  typedef enum logic [5:0] {
    ILT_OR_A_IND, ILT_OR_A_IMM, ILT_OR_DIR_A, ILT_OR_DIR_IMM,
    ILT_XOR_A_REG, ILT_XOR_A_DIR, ILT_XOR_A_IND, ILT_XOR_A_IMM,
    ILT_XOR_DIR_A, ILT_XOR_DIR_IMM,
    ILT_CLR_A, ILT_CPL_A, ILT_RL_A, ILT_RLC_A, ILT_RR_A, ILT_RRC_A, ILT_SWAP_A,
    ILT_MOV_A_REG, ILT_MOV_A_DIR, ILT_MOV_A_IND, ILT_MOV_A_IMM,
    ILT_MOV_REG_A, ILT_MOV_REG_DIR, ILT_MOV_REG_IMM,
    ILT_MOV_DIR_A, ILT_MOV_DIR_REG, ILT_MOV_DIR_DIR, ILT_MOV_DIR_IND, ILT_MOV_DIR_IMM,
    ILT_MOV_IND_A, ILT_MOV_IND_DIR, ILT_MOV_IND_IMM,
    ILT_MOV_SIXTEEN_BIT_DATA_POINTER_IMM,
    ILT_CODE_RD_DP, ILT_CODE_RD_PC,
    ILT_EXT_RD_IND, ILT_EXT_WR_IND, ILT_EXT_RD_DP, ILT_EXT_WR_DP,
    ILT_PUSH_DIR
  } ilt_op_t;

endpackage

// File: hdl/ilt_timing.sv
// Contract
// - OR indirect into A: 1 byte, 2 cycles; OR immediate into A: 2 bytes, 2.
// - OR A into direct: 2 bytes, 2 cycles; OR immediate into direct: 3, 3.
// - XOR register into A: 1 byte, 1 cycle; XOR direct into A: 2, 2.
// - XOR indirect into A: 1 byte, 2 cycles; XOR immediate into A: 2, 2.
// - XOR A into direct: 2 bytes, 2 cycles; XOR immediate into direct: 3, 3.
// - Rotate A left, plain or via carry: 1 byte, 1 cycle.
// - Rotate right, clear, complement, swap of A: 1 byte, 1 cycle each.
// - Load A: register 1/1, direct 2/2, indirect 1/2, immediate 2/2.
// - Load register: from A 1/1; from direct or immediate 2/2.
// - Store A or register into direct: 2 bytes, 2 cycles.
// - Direct to direct copy: 3 bytes, 3 cycles.
// - Indirect into direct 2/2; immediate into direct 3/3.
// - Into indirect: from A 1/2; from direct or immediate 2/2.
// - Load data pointer with 16-bit constant: 3 bytes, 3 cycles.
// - Code-memory read relative pointer or PC: 1 byte, 4 to 7 cycles.
// - Code read count depends on alignment and flash read timing field.
// - External move with 8-bit register address: 1 byte, 3 cycles.
// - External read via 16-bit data pointer: 1 byte, 3 cycles.
// - Push direct byte: 2 bytes, 2 cycles.
// - Stated counts hold only with prefetch enabled.
//
// Sequencer that accepts one instruction class and reports its length and
// counts its execution cycles, one per enabled core clock, until completion.
// Assumes the fetch side holds the request until accepted.
`timescale 1ns/10ps
module ilt_timing
(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             issue_valid,
  input  wire ilt_pkg::ilt_op_t issue_op,
  input  wire logic [1:0]       fetch_align,
  input  wire logic             prefetch_enable_flag,
  input  wire logic [1:0]       flash_read_timing_field,
  output logic                  issue_ready,
  output logic                  busy,
  output logic                  done,
  output logic [1:0]            instr_len,
  output logic [2:0]            instr_cyc,
  output logic                  timing_valid,
  output logic                  unknown_op
);
  typedef enum logic [1:0] {ILT_IDLE, ILT_EXEC} ilt_state_t;

  typedef struct packed {
    ilt_state_t state;
    logic [2:0] remain;
    logic       ready;
    logic       busy;
    logic       done;
    logic [1:0] len;
    logic [2:0] cyc;
    logic       tvalid;
    logic       unknown;
  } ilt_regs_t;

  ilt_regs_t  r;
  ilt_regs_t  next_r;
  logic [1:0] dec_len;
  logic [2:0] dec_cyc;
  logic       dec_code;
  logic       dec_known;
  logic [2:0] code_cyc;
  logic [2:0] eff_cyc;

  ilt_decode u_decode
  (
    .op         (issue_op),
    .len        (dec_len),
    .cyc        (dec_cyc),
    .is_code_rd (dec_code),
    .known      (dec_known)
  );

  ilt_code_extra u_code_extra
  (
    .fetch_align             (fetch_align),
    .flash_read_timing_field (flash_read_timing_field),
    .total_cyc               (code_cyc)
  );

  assign eff_cyc = dec_code ? code_cyc : dec_cyc;

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    unique case (r.state)
      ILT_IDLE:
      begin
        if (issue_valid)
        begin
          next_r.len     = dec_len;
          next_r.cyc     = eff_cyc;
          // Counts are only guaranteed with prefetch on.
          next_r.tvalid  = prefetch_enable_flag & dec_known;
          next_r.unknown = ~dec_known;
          if (!dec_known)
          begin
            next_r.done = 1'b1;
          end
          else if (eff_cyc == ilt_pkg::CYC_ONE)
          begin
            next_r.done = 1'b1;
          end
          else
          begin
            next_r.state  = ILT_EXEC;
            next_r.remain = eff_cyc - 3'h1;
            next_r.ready  = 1'b0;
            next_r.busy   = 1'b1;
          end
        end
      end
      ILT_EXEC:
      begin
        // One count per enabled core clock from fetch to completion.
        next_r.remain = r.remain - 3'h1;
        if (r.remain == 3'h1)
        begin
          next_r.state = ILT_IDLE;
          next_r.ready = 1'b1;
          next_r.busy  = 1'b0;
          next_r.done  = 1'b1;
        end
      end
      default:
      begin
        next_r.state = ILT_IDLE;
        next_r.ready = 1'b1;
        next_r.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      r         <= '0;
      r.state   <= ILT_IDLE;
      r.ready   <= 1'b1;
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  assign issue_ready  = r.ready;
  assign busy         = r.busy;
  assign done         = r.done;
  assign instr_len    = r.len;
  assign instr_cyc    = r.cyc;
  assign timing_valid = r.tvalid;
  assign unknown_op   = r.unknown;
endmodule

// File: sim/ilt_fetch_model.sv
// Fetch-side model: offers one instruction class and holds it until taken.
// Assumes the bench keeps go high until took is seen.
`timescale 1ns/10ps
module ilt_fetch_model
(
  input  wire logic             core_clk,
  input  wire logic             clk_en,
  input  wire logic             go,
  input  wire ilt_pkg::ilt_op_t go_op,
  input  wire logic             issue_ready,
  output logic                  issue_valid,
  output ilt_pkg::ilt_op_t      issue_op,
  output logic                  took
);
  initial
  begin
    issue_valid = 1'b0;
    issue_op = ilt_pkg::ILT_CLR_A;
    took = 1'b0;
  end
  always @(posedge core_clk)
    took <= issue_valid && issue_ready && clk_en;
  // A released class line shows the inverse so stale values never match.
  always @(negedge core_clk)
  begin
    if (took)
    begin
      issue_valid <= 1'b0;
      issue_op <= ilt_pkg::ilt_op_t'(~issue_op);
    end
    else if (go && !issue_valid)
    begin
      issue_valid <= 1'b1;
      issue_op <= go_op;
    end
  end
endmodule

// File: sim/ilt_timing_checker.sv
// Port checker for the instruction length and timing sequencer.
// Assumes one core clock and the asynchronous active-high reset.
`timescale 1ns/10ps
module ilt_timing_checker
(
  input wire logic             core_clk,
  input wire logic             reset,
  input wire logic             clk_en,
  input wire logic             issue_valid,
  input wire ilt_pkg::ilt_op_t issue_op,
  input wire logic [1:0]       fetch_align,
  input wire logic             prefetch_enable_flag,
  input wire logic [1:0]       flash_read_timing_field,
  input wire logic             issue_ready,
  input wire logic             busy,
  input wire logic             done,
  input wire logic [1:0]       instr_len,
  input wire logic [2:0]       instr_cyc,
  input wire logic             timing_valid,
  input wire logic             unknown_op
);
  wire        take = clk_en && issue_ready && issue_valid;
  logic [3:0] code_sum;
  logic [2:0] code_cap;
  assign code_sum = 4'h4 + 4'(flash_read_timing_field) + 4'(fetch_align != 2'h0);
  assign code_cap = (code_sum > 4'h7) ? 3'h7 : code_sum[2:0];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  a_busy_ready: assert property (busy |-> !issue_ready)
    else $error("ready while busy");
  a_one_cyc: assert property (take && issue_op == ilt_pkg::ILT_CLR_A |=> done && instr_cyc == 3'h1)
    else $error("clear not one cycle");
  a_two_cyc: assert property (take && issue_op == ilt_pkg::ILT_MOV_A_DIR ##1 clk_en |=> done && !busy)
    else $error("load direct not two cycles");
  a_three_cyc: assert property (take && issue_op == ilt_pkg::ILT_MOV_DIR_IMM ##1 clk_en [*2] |=>
    done)
    else $error("immediate to direct not three cycles");
  a_code_pc: assert property (take && issue_op == ilt_pkg::ILT_CODE_RD_PC |=>
    instr_cyc == $past(code_cap))
    else $error("code read count wrong");
  a_code_dp: assert property (take && issue_op == ilt_pkg::ILT_CODE_RD_DP |=>
    instr_len == 2'h1 && instr_cyc >= 3'h4)
    else $error("code read length or count wrong");
  a_ext_wr: assert property (take && issue_op == ilt_pkg::ILT_EXT_WR_DP |=>
    instr_len == 2'h1 && instr_cyc == 3'h3)
    else $error("external write timing wrong");
  a_valid_pf: assert property (take && issue_op <= ilt_pkg::ILT_PUSH_DIR |=>
    timing_valid == $past(prefetch_enable_flag))
    else $error("timing valid wrong");
  a_len_hold: assert property (busy && $past(busy) |-> $stable(instr_len) && $stable(instr_cyc))
    else $error("length changed while busy");
  a_unknown: assert property (take && issue_op > ilt_pkg::ILT_PUSH_DIR |=> unknown_op && done)
    else $error("unknown class not flagged");
endmodule
bind ilt_timing ilt_timing_checker i_chk (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
  .issue_valid(issue_valid), .issue_op(issue_op), .fetch_align(fetch_align),
  .prefetch_enable_flag(prefetch_enable_flag), .flash_read_timing_field(flash_read_timing_field),
  .issue_ready(issue_ready), .busy(busy), .done(done), .instr_len(instr_len), .instr_cyc(instr_cyc),
  .timing_valid(timing_valid), .unknown_op(unknown_op));

// File: sim/testbench.sv
// Self-checking bench for the instruction length and timing sequencer.
// Assumes the fetch model in front and the port checker bound inside.
`timescale 1ns/10ps
module testbench;
  logic             core_clk = 1'b0;
  logic             reset = 1'b1;
  logic             clk_en = 1'b1;
  logic             go = 1'b0;
  logic             prefetch_enable_flag = 1'b1;
  logic [1:0]       fetch_align = 2'h0;
  logic [1:0]       flash_read_timing_field = 2'h0;
  ilt_pkg::ilt_op_t go_op = ilt_pkg::ILT_CLR_A;
  ilt_pkg::ilt_op_t issue_op;
  logic             issue_valid, issue_ready, busy, done, timing_valid, unknown_op, took;
  logic [1:0]       instr_len;
  logic [2:0]       instr_cyc;
  int               err_count = 0;
  int               total_checks = 0;
  always #2 core_clk = ~core_clk;
  ilt_fetch_model i_fetch (.core_clk(core_clk), .clk_en(clk_en), .go(go), .go_op(go_op),
    .issue_ready(issue_ready), .issue_valid(issue_valid), .issue_op(issue_op), .took(took));
  ilt_timing i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .issue_valid(issue_valid),
    .issue_op(issue_op), .fetch_align(fetch_align), .prefetch_enable_flag(prefetch_enable_flag),
    .flash_read_timing_field(flash_read_timing_field), .issue_ready(issue_ready), .busy(busy),
    .done(done), .instr_len(instr_len), .instr_cyc(instr_cyc), .timing_valid(timing_valid),
    .unknown_op(unknown_op));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Issues one class, optionally freezes the clock enable, and counts cycles to done.
  task automatic run_op(input ilt_pkg::ilt_op_t op, input logic [1:0] len, input logic [2:0] cyc,
                        input logic unk, input int hold);
    int n;
    n = 1;
    go_op <= op;
    go <= 1'b1;
    @(negedge core_clk);
    while (took !== 1'b1)
      @(negedge core_clk);
    go <= 1'b0;
    check("unknown_op", 8'(unknown_op), 8'(unk));
    check("timing_valid", 8'(timing_valid), 8'(prefetch_enable_flag && !unk));
    check("issue_ready", 8'(issue_ready), 8'(unk || cyc == 3'h1));
    check("busy_take", 8'(busy), 8'(!unk && cyc != 3'h1));
    if (!unk)
    begin
      check("instr_len", 8'(instr_len), 8'(len));
      check("instr_cyc", 8'(instr_cyc), 8'(cyc));
    end
    if (hold > 0)
    begin
      clk_en <= 1'b0;
      repeat (hold) @(negedge core_clk);
      clk_en <= 1'b1;
      n = n + hold;
      check("busy", 8'(busy), 8'h1);
    end
    while (done !== 1'b1 && n < 16)
    begin
      @(negedge core_clk);
      n++;
    end
    check("cycles", 8'(n), 8'(cyc) + 8'(hold));
    // Lets an edge pass so the next call never drives go in this time step.
    @(negedge core_clk);
  endtask
  task automatic t_table;
    string            lt;
    string            ct;
    ilt_pkg::ilt_op_t op;
    logic [1:0]       l;
    logic [2:0]       c;
    int               h;
    lt = "1223121223111111112121222232312231111112";
    ct = "2223122223111111112221222232322230033332";
    for (int i = 0; i < 40; i++)
    begin
      op = ilt_pkg::ilt_op_t'(6'(i));
      l  = 2'(lt[i] - "0");
      c  = 3'(ct[i] - "0");
      h  = (i == 26) ? 2 : 0;
      if (i < 17)
        run_op(op, l, c, 1'b0, h);
      else if (i < 33)
        run_op(op, l, c, 1'b0, h);
      else if (i > 34)
        run_op(op, l, c, 1'b0, h);
    end
  endtask
  task automatic t_code;
    logic [3:0] e;
    for (int k = 0; k < 32; k++)
    begin
      flash_read_timing_field <= k[3:2];
      fetch_align <= k[1:0];
      e = 4'h4 + 4'(k[3:2]) + 4'(k[1:0] != 2'h0);
      if (e > 4'h7)
        e = 4'h7;
      run_op((k < 16) ? ilt_pkg::ILT_CODE_RD_DP : ilt_pkg::ILT_CODE_RD_PC, 2'h1, e[2:0], 1'b0, 0);
    end
  endtask
  task automatic t_nopf;
    prefetch_enable_flag <= 1'b0;
    run_op(ilt_pkg::ILT_PUSH_DIR, 2'h2, 3'h2, 1'b0, 0);
    prefetch_enable_flag <= 1'b1;
  endtask
  task automatic t_unknown;
    run_op(ilt_pkg::ilt_op_t'(6'h3f), 2'h0, 3'h1, 1'b1, 0);
  endtask
  // Pulls reset in the middle of a three-cycle op and checks that the sequencer recovers.
  task automatic t_reset;
    go_op <= ilt_pkg::ILT_MOV_SIXTEEN_BIT_DATA_POINTER_IMM;
    go <= 1'b1;
    @(negedge core_clk);
    while (took !== 1'b1)
      @(negedge core_clk);
    go <= 1'b0;
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    check("rst_busy", 8'(busy), 8'h0);
    check("rst_ready", 8'(issue_ready), 8'h1);
    check("rst_len", 8'(instr_len), 8'h0);
    reset = 1'b0;
    @(negedge core_clk);
    run_op(ilt_pkg::ILT_MOV_SIXTEEN_BIT_DATA_POINTER_IMM, 2'h3, 3'h3, 1'b0, 0);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    finish_test;
  end
  initial
  begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    t_table;
    t_code;
    t_nopf;
    t_unknown;
    t_reset;
    finish_test;
  end
endmodule
